// [bench/array_pe_datapath_assertions.sv]
`timescale 1ns/1ns
module array_pe_datapath_assertions (
   input wire logic sys_clk,
   input wire logic rst,
   input wire arr_pe_pkg::ctrl_s ctrl,
   input wire logic modeIn,
   input wire logic [63:0] extDataIn,
   input wire logic [63:0] routeIn,
   input wire logic [63:0] extDataOut,
   input wire logic [63:0] routeOut,
   input wire logic [15:0] memAddr,
   input wire logic [1:0] memLaneEn,
   input wire logic modeOut,
   input wire logic [5:0] expCorr
);
   import arr_pe_pkg::*;
   // every control acts two edges after it is presented
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_reset_state: assert property ($fell(rst) |-> memLaneEn == 2'h3 && extDataOut == 64'h0 && memAddr == 16'h0)
      else $error("reset state wrong");
   a_ext_load: assert property (ctrl.bSrc == B_EXT ##1 $stable(extDataIn) |=> extDataOut == $past(extDataIn))
      else $error("external word not in B");
   a_route_load: assert property (ctrl.rSrc == R_ROUTE ##1 $stable(routeIn) |=> routeOut == $past(routeIn))
      else $error("neighbour word not in R");
   a_b_hold: assert property (ctrl.bSrc == B_HOLD && !ctrl.mulStep |=> ##1 $stable(extDataOut))
      else $error("B changed while held");
   a_r_hold: assert property (ctrl.rSrc == R_HOLD && !ctrl.mulStep |=> ##1 $stable(routeOut))
      else $error("R changed while held");
   a_mul_b_shift: assert property (ctrl.mulStep |=> ##1 extDataOut == ($past(extDataOut) >> 8))
      else $error("multiplier byte not retired");
   a_mul_r_shift: assert property (ctrl.mulStep |=> ##1 routeOut == ($past(routeOut) << 8))
      else $error("multiplicand not advanced");
   a_addr_hold: assert property (!ctrl.marLoad |=> ##1 $stable(memAddr))
      else $error("address changed unasked");
   a_outer_write: assert property (ctrl.modeWr && ctrl.modeIdx == 3'h0 |=> ##1 memLaneEn[0] == $past(modeIn, 2))
      else $error("outer enable not written");
   a_inner_write: assert property (ctrl.modeWr && ctrl.modeIdx == 3'h1 |=> ##1 memLaneEn[1] == $past(modeIn, 2))
      else $error("inner enable not written");
   a_lane_hold: assert property (!ctrl.modeWr |=> ##1 $stable(memLaneEn))
      else $error("enables changed unasked");
   a_mode_read: assert property (ctrl.modeRd && ctrl.modeIdx == 3'h1 |=> ##1 modeOut == $past(memLaneEn[1]))
      else $error("mode readback wrong");
   a_read_hold: assert property (!ctrl.modeRd |=> ##1 $stable(modeOut))
      else $error("mode output changed unasked");
   a_corr_hold: assert property (ctrl.amtSrc != AMT_LOD |=> ##1 $stable(expCorr))
      else $error("count changed unasked");
endmodule : array_pe_datapath_assertions

bind array_pe_datapath array_pe_datapath_assertions u_array_pe_datapath_assertions (
   .sys_clk(sys_clk), .rst(rst), .ctrl(ctrl), .modeIn(modeIn), .extDataIn(extDataIn), .routeIn(routeIn),
   .extDataOut(extDataOut), .routeOut(routeOut), .memAddr(memAddr), .memLaneEn(memLaneEn),
   .modeOut(modeOut), .expCorr(expCorr));

// [bench/array_pe_datapath_tb_top.sv]
`timescale 1ns/1ns
module array_pe_datapath_tb_top;
   import arr_pe_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [63:0] extDataIn = 64'h0;
   logic [63:0] routeIn = 64'h0;
   ctrl_s ctrl;
   logic modeIn;
   logic [63:0] extDataOut;
   logic [63:0] routeOut;
   logic [15:0] memAddr;
   logic [1:0] memLaneEn;
   logic modeOut;
   logic [5:0] expCorr;
   int num_errors = 0;
   int num_checks = 0;
   int seed = 32'h97E4;
   int s;
   int w;
   logic [63:0] a = 64'h0;
   logic [63:0] b;
   logic [63:0] p;
   logic [7:0] md = 8'h03;
   logic [15:0] x;
   ctrl_s k;

   array_pe_datapath u_array_pe_datapath (.sys_clk(sys_clk), .rst(rst), .ctrl(ctrl), .modeIn(modeIn),
      .extDataIn(extDataIn), .routeIn(routeIn), .extDataOut(extDataOut), .routeOut(routeOut),
      .memAddr(memAddr), .memLaneEn(memLaneEn), .modeOut(modeOut), .expCorr(expCorr));
   seq_model u_seq_model (.sys_clk(sys_clk), .ctrl(ctrl), .modeIn(modeIn));

   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard; the guard is far beyond the few hundred cycles used
   initial forever #10 sys_clk = ~sys_clk;
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      print_verdict();
   end

   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   ////////////////////////////////////////////////////////////////////////
   // reference model helpers
   function automatic logic [63:0] rnd();
      return {$random(seed), $random(seed)};
   endfunction : rnd

   function automatic logic [63:0] msk();
      return (md[0] ? OUTER_MASK : 64'h0) | (md[1] ? INNER_MASK : 64'h0);
   endfunction : msk

   function automatic logic [63:0] add(logic [63:0] u, logic [63:0] v, bit lanes, bit sb);
      logic [63:0] o;
      o = sb ? u - v : u + v;
      for (int j = 0; j < 8; j++) begin
         if (lanes) o[j*8 +: 8] = sb ? u[j*8 +: 8] - v[j*8 +: 8] : u[j*8 +: 8] + v[j*8 +: 8];
      end
      return o;
   endfunction : add

   // bit-by-bit shift: end-off fills with zero, end-around wraps inside the width
   function automatic logic [63:0] sh(logic [63:0] v, int n, bit l, bit ar, int wd);
      logic [63:0] o;
      int t;
      o = 64'h0;
      for (int i = 0; i < wd; i++) begin
         t = l ? i - n : i + n;
         if (ar) t = (t + wd) % wd;
         if (t >= 0 && t < wd) o[i] = v[t];
      end
      return o;
   endfunction : sh

   // word or two independent half words; a half shift uses the amount modulo 32
   function automatic logic [63:0] shf(logic [63:0] v, int n, bit l, bit ar, bit hf);
      if (hf) return sh(v & 64'h0000_0000_FFFF_FFFF, n % 32, l, ar, 32) | (sh(v >> 32, n % 32, l, ar, 32) << 32);
      return sh(v, n, l, ar, 64);
   endfunction : shf

   ////////////////////////////////////////////////////////////////////////
   // drivers: every operation goes through the sequencer model
   task automatic go(input ctrl_s c);
      u_seq_model.send(c, 1'b0);
   endtask : go

   // let the two-edge pipeline drain, then step off the edge
   task automatic flush();
      go('0);
      go('0);
      #1;
   endtask : flush

   // data words held over both pipeline edges so the load sees them settled
   task automatic ld(input logic [63:0] v, input bit toR);
      k = '0;
      if (toR) k.rSrc = R_ROUTE;
      else k.bSrc = B_EXT;
      go(k);
      extDataIn <= v;
      routeIn <= v;
      go('0);
   endtask : ld

   // own enable word, so a caller's half-built k survives a mode write
   task automatic wm(input int i, input logic v);
      ctrl_s m;
      m = '0;
      m.modeWr = 1'b1;
      m.modeIdx = 3'(i);
      u_seq_model.send(m, v);
      md[i] = v;
   endtask : wm

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      flush();
      check(extDataOut, 64'h0);
      check(64'(memLaneEn), 64'h3);
      for (int i = 0; i < 4; i++) begin
         wm(M_OUTER, i[0]);
         wm(M_INNER, i[1]);
         p = rnd();
         b = rnd();
         ld(p, 1'b0);
         k = '0;
         k.aSrc = A_B;
         go(k);
         a = (a & ~msk()) | (p & msk());
         // signed add turns into a subtract on unlike signs
         if (i[1]) b[63] = ~a[63];
         ld(b, 1'b0);
         k.aSrc = A_SUM;
         k.fmt = i[0] ? FMT_BYTE : FMT_WORD;
         k.cpaOp = i[1] ? CPA_SIGNED : CPA_ADD;
         go(k);
         a = (a & ~msk()) | (add(a, b, i[0], i[1]) & msk());
         k = '0;
         k.bSrc = B_A;
         go(k);
         b = a;
         flush();
         check(extDataOut, a);
         check(64'(memLaneEn), 64'(i));
      end
      wm(M_OUTER, 1'b1);
      wm(M_INNER, 1'b1);
      x = 16'($random(seed));
      k = '0;
      k.xLoad = 1'b1;
      k.adaIn = ADA_OSG;
      k.imm = x;
      go(k);
      wm(M_OUTER, 1'b0);
      k.imm = ~x;
      go(k);
      wm(M_OUTER, 1'b1);
      k = '0;
      k.marLoad = 1'b1;
      k.adaIn = ADA_X;
      k.imm = 16'h1234;
      go(k);
      flush();
      check(64'(memAddr), 64'(16'(x + 16'h1234)));
      // store write with the inner bit off, read through the address adder
      wm(M_INNER, 1'b0);
      k = '0;
      k.sLoad = 1'b1;
      go(k);
      wm(M_INNER, 1'b1);
      k = '0;
      k.marLoad = 1'b1;
      k.adaIn = ADA_S;
      k.imm = 16'h0F0F;
      go(k);
      flush();
      check(64'(memAddr), 64'(16'({8'h00, a[7:0]} + 16'h0F0F)));
      p = rnd();
      ld(p, 1'b1);
      flush();
      check(routeOut, p);
      k = '0;
      k.rSrc = R_B;
      go(k);
      flush();
      check(routeOut, b);
      p = rnd();
      ld(p, 1'b0);
      for (int j = 0; j < 8; j++) begin
         s = $random(seed) & 63;
         k = '0;
         k.aSrc = A_SHIFT;
         k.shFromB = 1'b1;
         k.amtSrc = AMT_FIXED;
         k.shFixed = 6'(s);
         k.shLeft = j[0];
         k.shAround = j[1];
         k.fmt = j[2] ? FMT_HALF : FMT_WORD;
         go(k);
         k = '0;
         k.rSrc = R_A;
         go(k);
         flush();
         a = shf(p, s, j[0], j[1], j[2]);
         check(routeOut, a);
      end
      // leading-one count, junk above the field
      for (int j = 0; j < 6; j++) begin
         w = j[0] ? 24 : 48;
         s = (j < 2) ? w : (($random(seed) & 63) % w);
         p = (rnd() & ~(j[0] ? MANT32_MASK : MANT64_MASK)) | ((s < w) ? (64'h1 << s) : 64'h0);
         ld(p, 1'b0);
         k = '0;
         k.aSrc = A_B;
         go(k);
         k = '0;
         k.aSrc = A_SHIFT;
         k.amtSrc = AMT_LOD;
         k.fmt = j[0] ? FMT_HALF : FMT_WORD;
         go(k);
         k = '0;
         k.rSrc = R_A;
         go(k);
         flush();
         s = (s < w) ? w - 1 - s : w;
         check(64'(expCorr), 64'(s));
         // the count drives a left normalize shift
         check(routeOut, shf(p, s, 1'b1, 1'b0, j[0]));
      end
      // a normalize of a zero mantissa leaves the underflow fault set
      md[M_UNF] = 1'b1;
      k = '0;
      k.modeRd = 1'b1;
      k.modeIdx = 3'(M_UNF);
      go(k);
      flush();
      check(64'(modeOut), 64'(md[M_UNF]));
      // two steps retire sixteen multiplier bits, then A plus C resolves
      p = rnd();
      b = rnd();
      ld(64'h0, 1'b0);
      k = '0;
      k.aSrc = A_B;
      go(k);
      ld(p, 1'b1);
      ld(b, 1'b0);
      k = '0;
      k.mulStep = 1'b1;
      go(k);
      go(k);
      k = '0;
      k.aSrc = A_SUM;
      k.cpaOp = CPA_CSA;
      go(k);
      k = '0;
      k.bSrc = B_A;
      go(k);
      flush();
      check(extDataOut, (b & 64'hFFFF) * p);
      // each compare outcome lands in its test bit and reads back
      for (int j = 0; j < 4; j++) begin
         p = (j == 2) ? 64'h0 : rnd();
         b = (j == 0) ? p : rnd();
         ld(p, 1'b0);
         k = '0;
         k.aSrc = A_B;
         go(k);
         ld(b, 1'b0);
         k = '0;
         k.testWr = 1'b1;
         k.testOp = test_e'(j);
         k.testIdx = 2'(j);
         go(k);
         k = '0;
         k.modeRd = 1'b1;
         k.modeIdx = 3'(M_TEST + j);
         go(k);
         flush();
         md[M_TEST + j] = (j == 0) ? (p == b) : (j == 1) ? ($signed(p) < $signed(b))
                        : (j == 2) ? (p == 64'h0) : p[63];
         check(64'(modeOut), 64'(md[M_TEST + j]));
      end
      // mode bits written and read back
      for (int i = 0; i < 8; i++) begin
         wm(i, (i < 2) ? 1'b1 : 1'($random(seed)));
         go('0);
         k = '0;
         k.modeRd = 1'b1;
         k.modeIdx = 3'(i);
         go(k);
         flush();
         check(64'(modeOut), 64'(md[i]));
      end
      print_verdict();
   end
endmodule : array_pe_datapath_tb_top

// [bench/seq_model.sv]
`timescale 1ns/1ns
module seq_model (
   input wire logic sys_clk,
   output arr_pe_pkg::ctrl_s ctrl,
   output logic modeIn
);
   import arr_pe_pkg::*;
   // idle enables until an operation is asked for
   initial begin
      ctrl = '0;
      modeIn = 1'b0;
   end
   // decoded enables
   // one full enable word per clock, changed just after the edge so it is settled when sampled
   task automatic send(input ctrl_s c, input logic v);
      @(posedge sys_clk);
      ctrl <= c;
      modeIn <= v;
   endtask : send
endmodule : seq_model

// [inc/arr_pe_pkg.sv]
package arr_pe_pkg;
   localparam int WORD_W = 64;
   localparam int IDX_W = 16;
   localparam int MODE_W = 8;
   localparam int AMT_W = 6;
   localparam int BYTE_W = 8;
   localparam int HALF_W = 32;
   localparam int LANES = 8;
   localparam int MUL_BITS = 8;
   localparam int MANT64_W = 48;
   localparam int MANT32_W = 24;
   // word bits under each enable bit
   localparam logic [63:0] OUTER_MASK = 64'hFFFF_FF00_0000_00FF;
   localparam logic [63:0] INNER_MASK = 64'h0000_00FF_FFFF_FF00;
   localparam logic [63:0] MANT64_MASK = 64'h0000_FFFF_FFFF_FFFF;
   localparam logic [63:0] MANT32_MASK = 64'h0000_0000_00FF_FFFF;
   // mode bit positions
   localparam int M_OUTER = 0;
   localparam int M_INNER = 1;
   localparam int M_OVF = 2;
   localparam int M_UNF = 3;
   localparam int M_TEST = 4;
   localparam logic [7:0] MODE_RST = 8'h03;
   // carry break below each byte lane
   localparam logic [7:0] BRK_BYTE = 8'hFE;
   localparam logic [7:0] BRK_HALF = 8'h10;
   localparam logic [7:0] BRK_WORD = 8'h00;

   typedef enum logic [1:0] {FMT_WORD, FMT_HALF, FMT_BYTE} fmt_e;
   typedef enum logic [2:0] {A_HOLD, A_SUM, A_SHIFT, A_B, A_R, A_LOGIC} aSrc_e;
   typedef enum logic [2:0] {B_HOLD, B_EXT, B_A, B_R, B_INDEX} bSrc_e;
   typedef enum logic [1:0] {R_HOLD, R_ROUTE, R_A, R_B} rSrc_e;
   typedef enum logic [1:0] {ADA_X, ADA_S, ADA_OSG} adaIn_e;
   typedef enum logic [1:0] {AMT_ADA, AMT_FIXED, AMT_LOD} amt_e;
   typedef enum logic [2:0] {CPA_ADD, CPA_SUB, CPA_SIGNED, CPA_CSA, CPA_MANT} cpaOp_e;
   typedef enum logic [1:0] {LG_AND, LG_OR, LG_XOR, LG_NOT} logic_e;
   typedef enum logic [1:0] {T_EQ, T_LT, T_ZERO, T_NEG} test_e;

   // decoded enables from the sequencer, one cycle's worth
   typedef struct packed {
      fmt_e fmt;
      aSrc_e aSrc;
      bSrc_e bSrc;
      rSrc_e rSrc;
      logic cLoad;
      logic sLoad;
      logic xLoad;
      logic marLoad;
      adaIn_e adaIn;
      logic osgFromB;
      logic [15:0] imm;
      cpaOp_e cpaOp;
      logic shLeft;
      logic shAround;
      logic shFromB;
      amt_e amtSrc;
      logic [5:0] shFixed;
      logic mulStep;
      logic_e lgOp;
      logic testWr;
      test_e testOp;
      logic [1:0] testIdx;
      logic modeWr;
      logic modeRd;
      logic [2:0] modeIdx;
   } ctrl_s;
endpackage : arr_pe_pkg

// [logic/array_pe_datapath.sv]
`timescale 1ns/1ns
module array_pe_datapath (
   input wire logic sys_clk,
   input wire logic rst,
   input wire arr_pe_pkg::ctrl_s ctrl,
   input wire logic modeIn,
   input wire logic [arr_pe_pkg::WORD_W-1:0] extDataIn,
   input wire logic [arr_pe_pkg::WORD_W-1:0] routeIn,
   output logic [arr_pe_pkg::WORD_W-1:0] extDataOut,
   output logic [arr_pe_pkg::WORD_W-1:0] routeOut,
   output logic [arr_pe_pkg::IDX_W-1:0] memAddr,
   output logic [1:0] memLaneEn,
   output logic modeOut,
   output logic [arr_pe_pkg::AMT_W-1:0] expCorr
);
   import arr_pe_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane write mask from the two enable bits
   function automatic logic [63:0] laneMask(input logic [7:0] m);
      laneMask = (m[M_OUTER] ? OUTER_MASK : 64'h0) | (m[M_INNER] ? INNER_MASK : 64'h0);
   endfunction : laneMask

   // keep the enabled part of the new value, the old value elsewhere
   function automatic logic [63:0] merge(input logic [63:0] nv, input logic [63:0] ov,
                                         input logic [63:0] msk);
      merge = (nv & msk) | (ov & ~msk);
   endfunction : merge

   // one 3:2 carry-save layer, carry packed in the upper word
   function automatic logic [127:0] carry_save_adders(input logic [63:0] x, input logic [63:0] y,
                                        input logic [63:0] z);
      logic [63:0] maj;
      maj = (x & y) | (x & z) | (y & z);
      carry_save_adders = {maj << 1, x ^ y ^ z};
   endfunction : carry_save_adders

   // leading zeros of the mantissa field, 24 or 48 bits wide
   function automatic logic [5:0] lzc(input logic [47:0] v, input logic half);
      logic found;
      logic [5:0] n;
      found = 1'b0;
      n = 6'h00;
      for (int i = MANT64_W - 1; i >= 0; i--) begin
         if ((!half || i < MANT32_W) && !found) begin
            if (v[i]) begin
               found = 1'b1;
            end else begin
               n = n + 6'h01;
            end
         end
      end
      lzc = n;
   endfunction : lzc

   ////////////////////////////////////////////////////////////////////////
   // state

   ctrl_s cq;
   logic modeInQ;
   logic [63:0] aQ;
   logic [63:0] bQ;
   logic [63:0] cQ;
   logic [63:0] rQ;
   logic [63:0] sQ;
   logic [15:0] xQ;
   logic [15:0] marQ;
   logic [7:0] modeQ;
   logic modeOutQ;
   logic [5:0] expQ;

   logic [63:0] aD;
   logic [63:0] bD;
   logic [63:0] cD;
   logic [63:0] rD;
   logic [63:0] sD;
   logic [15:0] xD;
   logic [15:0] marD;
   logic [7:0] modeD;

   // retime controls
   // the sequencer's wires can be long; one register stage keeps the
   // whole element on a single clean edge at the cost of a cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cq <= '0;
         modeInQ <= 1'b0;
      end else begin
         cq <= ctrl;
         modeInQ <= modeIn;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // local enable modification

   logic [63:0] wrMask;
   logic isHalf;
   logic [63:0] mantMask;
   logic subtract;

   assign wrMask = laneMask(modeQ);
   assign isHalf = (cq.fmt == FMT_HALF);
   assign mantMask = isHalf ? MANT32_MASK : MANT64_MASK;
   assign subtract = (cq.cpaOp == CPA_SUB) || ((cq.cpaOp == CPA_SIGNED) && (aQ[63] ^ bQ[63]));

   ////////////////////////////////////////////////////////////////////////
   // address adder

   logic [15:0] operand_select_gates;
   logic [15:0] adaA;
   logic [15:0] adaB;
   logic [15:0] adaSum;

   assign operand_select_gates = cq.osgFromB ? bQ[15:0] : cq.imm;
   assign adaA = (cq.adaIn == ADA_X) ? xQ : ((cq.adaIn == ADA_S) ? sQ[15:0] : operand_select_gates);
   // the displacement indexes X or S; an operand alone goes through unchanged
   assign adaB = (cq.adaIn == ADA_OSG) ? 16'h0000 : cq.imm;
   assign adaSum = adaA + adaB;

   ////////////////////////////////////////////////////////////////////////
   // carry propagate adder

   logic [63:0] cpaA;
   logic [63:0] cpaB;
   logic [63:0] cpaSum;
   logic [63:0] cpaCy;
   logic [7:0] brk;
   logic isMant;
   logic ovf;

   assign isMant = (cq.cpaOp == CPA_MANT);
   assign cpaA = isMant ? (aQ & mantMask) : aQ;
   assign cpaB = (cq.cpaOp == CPA_CSA) ? cQ : (isMant ? ((subtract ? ~bQ : bQ) & mantMask)
                                                       : (subtract ? ~bQ : bQ));
   assign brk = isMant ? BRK_WORD : ((cq.fmt == FMT_BYTE) ? BRK_BYTE : (isHalf ? BRK_HALF : BRK_WORD));

   carry_prop_adder u_cpa (
      .opA(cpaA),
      .opB(cpaB),
      .cin(subtract),
      .brk(brk),
      .sum(cpaSum),
      .carries(cpaCy)
   );

   // mantissa carry-out or signed word overflow raises the fault
   assign ovf = isMant ? (isHalf ? cpaCy[MANT32_W-1] : cpaCy[MANT64_W-1])
                       : ((cq.fmt == FMT_WORD) && (cpaA[63] == cpaB[63]) && (cpaSum[63] != cpaA[63]));

   ////////////////////////////////////////////////////////////////////////
   // multiplier step

   logic [63:0] mulSum;
   logic [63:0] mulCar;

   // eight bits per step
   // multiplier in B (low byte), multiplicand in R, running sum and carry
   // in A and C; the final CPA_CSA add resolves them. Only the low word of
   // the product is kept, so callers must range the operands.
   always_comb begin
      logic [127:0] t;
      t = '0;
      mulSum = aQ;
      mulCar = cQ;
      for (int i = 0; i < MUL_BITS; i++) begin
         t = carry_save_adders(mulSum, mulCar, bQ[i] ? (rQ << i) : 64'h0);
         mulSum = t[63:0];
         mulCar = t[127:64];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shifting and normalization

   logic [5:0] lodCount;
   logic lodZero;
   logic [5:0] shAmt;
   logic shLeftEff;
   logic [63:0] shOut;

   assign lodCount = lzc(aQ[47:0], isHalf);
   assign lodZero = ((aQ & mantMask) == 64'h0);
   assign shAmt = (cq.amtSrc == AMT_ADA) ? adaSum[5:0] : ((cq.amtSrc == AMT_FIXED) ? cq.shFixed : lodCount);
   assign shLeftEff = cq.shLeft || (cq.amtSrc == AMT_LOD);

   barrel_shifter u_bsw (
      .din(cq.shFromB ? bQ : aQ),
      .amt(shAmt),
      .left(shLeftEff),
      .around(cq.shAround),
      .half(isHalf),
      .dout(shOut)
   );

   ////////////////////////////////////////////////////////////////////////
   // logic unit and tests

   logic [63:0] lgOut;
   logic testBit;

   assign lgOut = (cq.lgOp == LG_AND) ? (aQ & bQ) : ((cq.lgOp == LG_OR) ? (aQ | bQ)
                : ((cq.lgOp == LG_XOR) ? (aQ ^ bQ) : ~aQ));
   assign testBit = (cq.testOp == T_EQ) ? (aQ == bQ) : ((cq.testOp == T_LT) ? ($signed(aQ) < $signed(bQ))
                  : ((cq.testOp == T_ZERO) ? (aQ == 64'h0) : aQ[63]));

   ////////////////////////////////////////////////////////////////////////
   // register next values

   logic [63:0] aNew;

   always_comb begin
      case (cq.aSrc)
         A_SUM: aNew = isMant ? merge(cpaSum, aQ, mantMask) : cpaSum;
         A_SHIFT: aNew = shOut;
         A_B: aNew = bQ;
         A_R: aNew = rQ;
         A_LOGIC: aNew = lgOut;
         default: aNew = aQ;
      endcase
   end

   assign aD = cq.mulStep ? merge(mulSum, aQ, wrMask) : merge(aNew, aQ, wrMask);
   assign sD = cq.sLoad ? merge(aQ, sQ, wrMask) : sQ;
   assign cD = cq.mulStep ? mulCar : (cq.cLoad ? cpaCy : cQ);

   always_comb begin
      case (cq.bSrc)
         B_EXT: bD = extDataIn;
         B_A: bD = aQ;
         B_R: bD = rQ;
         B_INDEX: bD = {48'h0, adaSum};
         default: bD = bQ;
      endcase
      // a multiply step retires the low multiplier byte
      if (cq.mulStep) begin
         bD = bQ >> MUL_BITS;
      end
   end

   always_comb begin
      case (cq.rSrc)
         R_ROUTE: rD = routeIn;
         R_A: rD = aQ;
         R_B: rD = bQ;
         default: rD = rQ;
      endcase
      if (cq.mulStep) begin
         rD = rQ << MUL_BITS;
      end
   end

   assign xD = (cq.xLoad && modeQ[M_OUTER]) ? adaSum : xQ;
   assign marD = cq.marLoad ? adaSum : marQ;

   // sequencer writes
   // the sequencer write goes first so a fault seen in the same cycle
   // still sticks: hardware set wins over a software clear
   always_comb begin
      modeD = modeQ;
      if (cq.modeWr) begin
         modeD[cq.modeIdx] = modeInQ;
      end
      if (cq.testWr) begin
         modeD[M_TEST + int'(cq.testIdx)] = testBit;
      end
      if ((cq.aSrc == A_SUM) && ovf) begin
         modeD[M_OVF] = 1'b1;
      end
      if ((cq.aSrc == A_SHIFT) && (cq.amtSrc == AMT_LOD) && lodZero) begin
         modeD[M_UNF] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aQ <= 64'h0;
         bQ <= 64'h0;
         cQ <= 64'h0;
         rQ <= 64'h0;
         sQ <= 64'h0;
         xQ <= 16'h0000;
         marQ <= 16'h0000;
      end else begin
         aQ <= aD;
         bQ <= bD;
         cQ <= cD;
         rQ <= rD;
         sQ <= sD;
         xQ <= xD;
         marQ <= marD;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         modeQ <= MODE_RST;
         modeOutQ <= 1'b0;
         expQ <= 6'h00;
      end else begin
         modeQ <= modeD;
         if (cq.modeRd) begin
            modeOutQ <= modeQ[cq.modeIdx];
         end
         if (cq.amtSrc == AMT_LOD) begin
            expQ <= lodCount;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from registers

   assign extDataOut = bQ;
   assign routeOut = rQ;
   assign memAddr = marQ;
   assign memLaneEn = modeQ[M_INNER:M_OUTER];
   assign modeOut = modeOutQ;
   assign expCorr = expQ;
endmodule : array_pe_datapath

// [logic/barrel_shifter.sv]
`timescale 1ns/1ns
module barrel_shifter (
   input wire logic [63:0] din,
   input wire logic [5:0] amt,
   input wire logic left,
   input wire logic around,
   input wire logic half,
   output logic [63:0] dout
);
   import arr_pe_pkg::*;

   logic [5:0] rAmt;
   logic [127:0] dbl64;
   logic [63:0] dblLo;
   logic [63:0] dblHi;
   logic [63:0] mask64;
   logic [31:0] mask32;

   // a left shift is a right rotate by the complement amount
   assign rAmt = left ? (~amt + 6'h01) : amt;
   assign dbl64 = {din, din} >> rAmt;
   assign dblLo = {din[31:0], din[31:0]} >> rAmt[4:0];
   assign dblHi = {din[63:32], din[63:32]} >> rAmt[4:0];
   // end-off discards the bits that wrapped round
   assign mask64 = around ? {64{1'b1}} : (left ? ({64{1'b1}} << amt) : ({64{1'b1}} >> amt));
   assign mask32 = around ? {32{1'b1}} : (left ? ({32{1'b1}} << amt[4:0]) : ({32{1'b1}} >> amt[4:0]));
   assign dout = half ? {dblHi[31:0] & mask32, dblLo[31:0] & mask32} : (dbl64[63:0] & mask64);
endmodule : barrel_shifter

// [logic/carry_prop_adder.sv]
`timescale 1ns/1ns
module carry_prop_adder (
   input wire logic [63:0] opA,
   input wire logic [63:0] opB,
   input wire logic cin,
   input wire logic [7:0] brk,
   output logic [63:0] sum,
   output logic [63:0] carries
);
   import arr_pe_pkg::*;

   logic [63:0] gen;
   logic [63:0] prop;
   logic [63:0] cyIn;
   logic [7:0] laneG;
   logic [7:0] laneP;
   logic [7:0] laneC;
   logic c;

   assign gen = opA & opB;
   assign prop = opA ^ opB;

   // bit, lane and word look-ahead; a set brk bit restarts the lane at cin
   always_comb begin
      c = 1'b0;
      for (int k = 0; k < LANES; k++) begin
         laneG[k] = 1'b0;
         laneP[k] = 1'b1;
         for (int i = 0; i < BYTE_W; i++) begin
            laneG[k] = gen[k*BYTE_W+i] | (prop[k*BYTE_W+i] & laneG[k]);
            laneP[k] = laneP[k] & prop[k*BYTE_W+i];
         end
      end
      laneC[0] = cin;
      for (int k = 1; k < LANES; k++) begin
         laneC[k] = brk[k] ? cin : (laneG[k-1] | (laneP[k-1] & laneC[k-1]));
      end
      for (int k = 0; k < LANES; k++) begin
         c = laneC[k];
         for (int i = 0; i < BYTE_W; i++) begin
            cyIn[k*BYTE_W+i] = c;
            c = gen[k*BYTE_W+i] | (prop[k*BYTE_W+i] & c);
            carries[k*BYTE_W+i] = c;
         end
      end
   end

   assign sum = prop ^ cyIn;
endmodule : carry_prop_adder
